// ===== fpfc_defs.svh
`ifndef FPFC_DEFS_SVH
`define FPFC_DEFS_SVH

// ****************************************
// Format geometry
// ****************************************
`define FPFC_SGL_EXP_W    8
`define FPFC_SGL_FRAC_W   23
`define FPFC_DBL_EXP_W    11
`define FPFC_DBL_FRAC_W   52
`define FPFC_EXT_EXP_W    15
`define FPFC_EXT_FRAC_W   63
`define FPFC_EXT_INT_POS  63
`define FPFC_EXT_FMSB_POS 62
`define FPFC_SGL_SIGN_POS 31
`define FPFC_DBL_SIGN_POS 63
`define FPFC_EXT_SIGN_POS 79
`define FPFC_SGL_EXP_LSB  23
`define FPFC_DBL_EXP_LSB  52
`define FPFC_EXT_EXP_LSB  64
`define FPFC_SGL_EXP_ONES 15'h00FF
`define FPFC_DBL_EXP_ONES 15'h07FF
`define FPFC_EXT_EXP_ONES 15'h7FFF
`define FPFC_MIN_EXP      17'h00001

// ****************************************
// Biases and byte counts
// ****************************************
`define FPFC_SGL_BIAS     17'h0007F
`define FPFC_DBL_BIAS     17'h003FF
`define FPFC_EXT_BIAS     17'h03FFF
`define FPFC_SGL_BYTES    4'h4
`define FPFC_DBL_BYTES    4'h8
`define FPFC_EXT_BYTES    4'hA

`endif

// ===== fpfc_pkg.sv
package fpfc_pkg;
    typedef enum logic [1:0] {
        FPFC_FMT_SGL = 2'h0,
        FPFC_FMT_DBL = 2'h1,
        FPFC_FMT_EXT = 2'h2
    } fpfc_fmt_e;

    typedef enum logic [7:0] {
        FPFC_CLS_ZERO   = 8'h01,
        FPFC_CLS_DENORM = 8'h02,
        FPFC_CLS_NORMAL = 8'h04,
        FPFC_CLS_INF    = 8'h08,
        FPFC_CLS_SNAN   = 8'h10,
        FPFC_CLS_QNAN   = 8'h20,
        FPFC_CLS_INDEF  = 8'h40,
        FPFC_CLS_BAD    = 8'h80
    } fpfc_cls_e;
endpackage

// ===== fpfc_unpack.sv
`timescale 1ns/1ps
`include "fpfc_defs.svh"

// Leaf: splits one raw operand into fields, aligning all formats to the extended layout.
module fpfc_unpack (
    // Operand
    input  wire logic [79:0]        raw,
    input  wire fpfc_pkg::fpfc_fmt_e fmt,
    // Fields
    output logic                    sign,
    output logic [14:0]             exp,
    output logic [14:0]             exp_ones,
    output logic                    int_stored,
    output logic [62:0]             frac,
    output logic [16:0]             bias,
    output logic [3:0]              nbytes
);
    import fpfc_pkg::*;

    always_comb begin
        int_stored = 1'b0;
        case (fmt)
            FPFC_FMT_SGL: begin
                sign     = raw[`FPFC_SGL_SIGN_POS];
                exp      = {7'h00, raw[`FPFC_SGL_EXP_LSB +: `FPFC_SGL_EXP_W]};
                exp_ones = `FPFC_SGL_EXP_ONES;
                frac     = {raw[`FPFC_SGL_FRAC_W-1:0], 40'h0000000000};
                bias     = `FPFC_SGL_BIAS;
                nbytes   = `FPFC_SGL_BYTES;
            end
            FPFC_FMT_DBL: begin
                sign     = raw[`FPFC_DBL_SIGN_POS];
                exp      = {4'h0, raw[`FPFC_DBL_EXP_LSB +: `FPFC_DBL_EXP_W]};
                exp_ones = `FPFC_DBL_EXP_ONES;
                frac     = {raw[`FPFC_DBL_FRAC_W-1:0], 11'h000};
                bias     = `FPFC_DBL_BIAS;
                nbytes   = `FPFC_DBL_BYTES;
            end
            default: begin
                sign       = raw[`FPFC_EXT_SIGN_POS];
                exp        = raw[`FPFC_EXT_EXP_LSB +: `FPFC_EXT_EXP_W];
                exp_ones   = `FPFC_EXT_EXP_ONES;
                int_stored = raw[`FPFC_EXT_INT_POS];
                frac       = raw[`FPFC_EXT_FRAC_W-1:0];
                bias       = `FPFC_EXT_BIAS;
                nbytes     = `FPFC_EXT_BYTES;
            end
        endcase
    end
endmodule

// ===== fpfc_top.sv
`timescale 1ns/1ps
`include "fpfc_defs.svh"

module fpfc_top #(
    parameter int RAW_W = 80,
    parameter int SIG_W = 64
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // Operand in
    input  wire logic                in_valid,
    input  wire logic [RAW_W-1:0]    in_raw,
    input  wire fpfc_pkg::fpfc_fmt_e in_fmt,
    // Result out
    output logic                     out_valid,
    output logic                     out_sign,
    output logic signed [16:0]       out_exp,
    output logic [14:0]              out_exp_biased,
    output logic [SIG_W-1:0]         out_signif,
    output logic [7:0]               out_class,
    output logic [3:0]               out_nbytes
);
    import fpfc_pkg::*;

    // ****************************************
    // Parameter check
    // ****************************************
    // The field split is wired for the widest format, so other widths cannot be served.
    if ((RAW_W != (`FPFC_EXT_SIGN_POS + 1)) || (SIG_W != (`FPFC_EXT_FRAC_W + 1))) begin : g_bad_width
        $error("fpfc_top serves only an 80-bit operand and a 64-bit significand");
    end

    // Format code 3 is unused and decodes as extended, matching the field split.
    function automatic logic fmt_is_ext(input fpfc_fmt_e f);
        return (f != FPFC_FMT_SGL) && (f != FPFC_FMT_DBL);
    endfunction

    typedef struct packed {
        logic        valid;
        logic        sign;
        logic [16:0] exp;
        logic [14:0] exp_biased;
        logic [63:0] signif;
        logic [7:0]  cls;
        logic [3:0]  nbytes;
    } fpfc_state_s;

    fpfc_state_s state_ff;
    fpfc_state_s nxt_state;

    logic        u_sign;
    logic [14:0] u_exp;
    logic [14:0] u_ones;
    logic        u_int;
    logic [62:0] u_frac;
    logic [16:0] u_bias;
    logic [3:0]  u_nbytes;

    fpfc_unpack u_unpack (
        .raw        (in_raw),
        .fmt        (in_fmt),
        .sign       (u_sign),
        .exp        (u_exp),
        .exp_ones   (u_ones),
        .int_stored (u_int),
        .frac       (u_frac),
        .bias       (u_bias),
        .nbytes     (u_nbytes)
    );

    // ****************************************
    // Classification
    // ****************************************
    logic exp_max;
    logic exp_zero;
    logic frac_zero;
    logic fmsb;
    logic frac_rest_zero;
    logic int_bit;
    logic [7:0] cls;

    always_comb begin
        exp_max        = (u_exp == u_ones);
        exp_zero       = (u_exp == 15'h0000);
        frac_zero      = (u_frac == 63'h0);
        fmsb           = u_frac[`FPFC_EXT_FMSB_POS];
        frac_rest_zero = (u_frac[`FPFC_EXT_FMSB_POS-1:0] == 62'h0);
        // Implied bit is supplied for the short formats only.
        if (fmt_is_ext(in_fmt)) begin
            int_bit = u_int;
        end else begin
            int_bit = !exp_zero;
        end
        if (exp_max) begin
            if (frac_zero) begin
                cls = FPFC_CLS_INF;
            end else if (!fmsb) begin
                cls = FPFC_CLS_SNAN;
            end else if (u_sign && frac_rest_zero) begin
                cls = FPFC_CLS_INDEF;
            end else begin
                cls = FPFC_CLS_QNAN;
            end
        end else if (exp_zero) begin
            cls = frac_zero ? FPFC_CLS_ZERO : FPFC_CLS_DENORM;
        end else begin
            cls = FPFC_CLS_NORMAL;
        end
        // An extended operand with the wrong stored integer bit is an unsupported encoding.
        if (fmt_is_ext(in_fmt) && (u_int != !exp_zero)) begin
            cls = cls | FPFC_CLS_BAD;
        end
    end

    // ****************************************
    // State update
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.valid = in_valid;
        if (in_valid) begin
            nxt_state.sign       = u_sign;
            // Denormals use the minimum exponent, 1 minus the bias.
            nxt_state.exp        = exp_zero ? (`FPFC_MIN_EXP - u_bias)
                                            : ({2'h0, u_exp} - u_bias);
            nxt_state.exp_biased = u_exp;
            nxt_state.signif     = {int_bit, u_frac};
            nxt_state.cls        = cls;
            nxt_state.nbytes     = u_nbytes;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    assign out_valid      = state_ff.valid;
    assign out_sign       = state_ff.sign;
    assign out_exp        = state_ff.exp;
    assign out_exp_biased = state_ff.exp_biased;
    assign out_signif     = state_ff.signif;
    assign out_class      = state_ff.cls;
    assign out_nbytes     = state_ff.nbytes;
endmodule

// ===== fpfc_lsu_model.sv
`timescale 1ns/1ps
module fpfc_lsu_model (
    // Clock in, operand out
    input  wire logic                clk,
    output logic                     in_valid,
    output logic [79:0]              in_raw,
    output fpfc_pkg::fpfc_fmt_e      in_fmt
);
    import fpfc_pkg::*;
    initial begin
        in_valid = 1'b0;
        in_raw   = 80'h0;
        in_fmt   = FPFC_FMT_SGL;
    end
    // Leaves the operand standing after the taking edge, so streams can run back to back.
    task automatic present(input logic [79:0] r, input fpfc_fmt_e f);
        in_raw   = r;
        in_fmt   = f;
        in_valid = 1'b1;
        @(posedge clk);
        #1;
    endtask
    // Idle operand bits are inverted, so stale data can never pass for a fresh load.
    task automatic go_idle;
        in_valid = 1'b0;
        in_raw   = ~in_raw;
        @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [79:0] r, input fpfc_fmt_e f);
        present(r, f);
        go_idle;
    endtask
endmodule

// ===== fpfc_top_checker.sv
`timescale 1ns/1ps
module fpfc_top_checker (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                clk_en,
    // Operand in
    input wire logic                in_valid,
    input wire logic [79:0]         in_raw,
    input wire fpfc_pkg::fpfc_fmt_e in_fmt,
    // Result out
    input wire logic signed [16:0]  out_exp,
    input wire logic [63:0]         out_signif,
    input wire logic [7:0]          out_class
);
    import fpfc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic        tk, sg, ex;
    logic [7:0]  e8;
    logic [14:0] e15;
    assign tk  = clk_en && in_valid;
    assign sg  = tk && in_fmt == FPFC_FMT_SGL;
    assign ex  = tk && in_fmt == FPFC_FMT_EXT;
    assign e8  = in_raw[30:23];
    assign e15 = in_raw[78:64];
    a_bias_sgl: assert property (sg && e8 != 8'h00 && e8 != 8'hFF |=>
        out_exp == 17'($past(e8)) - 17'h0007F) else $error("single exponent wrong");
    a_bias_ext: assert property (ex && e15 != 15'h0 && e15 != 15'h7FFF |=>
        out_exp == 17'($past(e15)) - 17'h03FFF) else $error("extended exponent wrong");
    a_implied_int: assert property (sg |=>
        out_signif[63] == ($past(e8) != 8'h00)) else $error("implied bit wrong");
    a_ext_int_pos: assert property (ex |=>
        out_signif[63:62] == $past(in_raw[63:62])) else $error("extended bits wrong");
    a_ext_bad_int: assert property (ex && (e15 != 15'h0) != in_raw[63] |=>
        out_class[7]) else $error("bad integer bit missed");
    a_snan_sgl: assert property (sg && e8 == 8'hFF && !in_raw[22] && in_raw[21:0] != 22'h0 |=>
        out_class == FPFC_CLS_SNAN) else $error("signalling NaN missed");
    a_inf_sgl: assert property (sg && in_raw[30:0] == 31'h7F800000 |=>
        out_class == FPFC_CLS_INF) else $error("infinity missed");
    a_indef_sgl: assert property (sg && in_raw[31:0] == 32'hFFC00000 |=>
        out_class == FPFC_CLS_INDEF) else $error("indefinite missed");
    a_frozen_hold: assert property (!clk_en |=>
        $stable(out_class) && $stable(out_signif)) else $error("state moved while frozen");
    c_snan: cover property (sg ##1 out_class == FPFC_CLS_SNAN);
    c_ext: cover property (ex ##1 out_class[7]);
    c_indef: cover property (out_class == FPFC_CLS_INDEF);
endmodule
bind fpfc_top fpfc_top_checker u_chk (.*);

// ===== tb_fpfc_top.sv
`timescale 1ns/1ps
module tb_fpfc_top;
    import fpfc_pkg::*;
    localparam logic [63:0] ONE = 64'h8000000000000000;
    localparam logic [63:0] QB  = 64'hC000000000000000;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               clk_en = 1'b1;
    logic               in_valid;
    logic [79:0]        in_raw;
    fpfc_fmt_e          in_fmt;
    logic               out_valid;
    logic               out_sign;
    logic [14:0]        out_exp_biased;
    logic signed [16:0] out_exp;
    logic [63:0]        out_signif;
    logic [7:0]         out_class;
    logic [3:0]         out_nbytes;
    int                 error_cnt = 0;
    int                 compares = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    fpfc_lsu_model lsu (.clk(clk), .in_valid(in_valid), .in_raw(in_raw), .in_fmt(in_fmt));
    fpfc_top uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .in_valid(in_valid),
        .in_raw(in_raw), .in_fmt(in_fmt), .out_valid(out_valid), .out_sign(out_sign),
        .out_exp(out_exp), .out_exp_biased(out_exp_biased), .out_signif(out_signif),
        .out_class(out_class),
        .out_nbytes(out_nbytes));
    task automatic close_out;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk(input logic [79:0] r, input fpfc_fmt_e f, input logic [7:0] c,
                       input logic [16:0] x, input logic [63:0] s, input logic [3:0] b);
        lsu.send(r, f);
        cmp("class", c, out_class);
        cmp("exp", x, {out_exp});
        cmp("signif", s, out_signif);
        cmp("nbytes", b, out_nbytes);
        cmp("valid drop", 64'h0, {63'h0, out_valid});
    endtask
    // Back-to-back operands, a frozen cycle, format code 3 and a reset in mid-run.
    task automatic t_stream;
        lsu.present(80'hC0000000, FPFC_FMT_SGL);
        cmp("valid", 64'h1, {63'h0, out_valid});
        cmp("sign", 64'h1, {63'h0, out_sign});
        cmp("biased", 64'h80, {49'h0, out_exp_biased});
        cmp("exp", 64'h1, {47'h0, out_exp});
        clk_en = 1'b0;
        lsu.present(80'h7FF0000000000000, FPFC_FMT_DBL);
        cmp("frozen class", 64'h04, {56'h0, out_class});
        cmp("frozen sign", 64'h1, {63'h0, out_sign});
        clk_en = 1'b1;
        lsu.present(80'h7FF0000000000000, FPFC_FMT_DBL);
        cmp("class", 64'h08, {56'h0, out_class});
        cmp("biased", 64'h7FF, {49'h0, out_exp_biased});
        cmp("exp", 64'h400, {47'h0, out_exp});
        cmp("sign", 64'h0, {63'h0, out_sign});
        cmp("valid", 64'h1, {63'h0, out_valid});
        lsu.present(80'h3FFF4000000000000000, fpfc_fmt_e'(2'h3));
        cmp("class", 64'h84, {56'h0, out_class});
        cmp("signif", 64'h4000000000000000, out_signif);
        cmp("nbytes", 64'hA, {60'h0, out_nbytes});
        rst_n = 1'b0;
        lsu.go_idle;
        rst_n = 1'b1;
        cmp("reset class", 64'h0, {56'h0, out_class});
        cmp("reset valid", 64'h0, {63'h0, out_valid});
        cmp("reset signif", 64'h0, out_signif);
    endtask
    task automatic t_single;
        chk(80'h3F800000, FPFC_FMT_SGL, 8'h04, 17'h0, ONE, 4'h4);
        chk(80'h1, FPFC_FMT_SGL, 8'h02, 17'h1FF82, 64'h10000000000, 4'h4);
        chk(80'h7F800000, FPFC_FMT_SGL, 8'h08, 17'h80, ONE, 4'h4);
        chk(80'h7F800001, FPFC_FMT_SGL, 8'h10, 17'h80, 64'h8000010000000000, 4'h4);
        chk(80'h7FC00000, FPFC_FMT_SGL, 8'h20, 17'h80, QB, 4'h4);
        chk(80'hFFC00000, FPFC_FMT_SGL, 8'h40, 17'h80, QB, 4'h4);
    endtask
    task automatic t_double;
        chk(80'h3FF0000000000000, FPFC_FMT_DBL, 8'h04, 17'h0, ONE, 4'h8);
        chk(80'h8000000000000000, FPFC_FMT_DBL, 8'h01, 17'h1FC02, 64'h0, 4'h8);
    endtask
    task automatic t_extend;
        chk(80'h3FFF8000000000000000, FPFC_FMT_EXT, 8'h04, 17'h0, ONE, 4'hA);
        chk(80'h7FFF8000000000000001, FPFC_FMT_EXT, 8'h10, 17'h4000, ONE + 1, 4'hA);
        lsu.send(80'h3FFF4000000000000000, FPFC_FMT_EXT);
        cmp("bad int", 64'h1, {63'h0, out_class[7]});
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cmp("reset class", 64'h0, {56'h0, out_class});
        t_single;
        t_stream;
        t_double;
        t_extend;
        close_out;
    end
    // About forty clock cycles are needed; the margin covers a stuck clock.
    initial begin
        #5000;
        error_cnt++;
        close_out;
    end
endmodule
